/* pcw_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pcw_host_model (
  input  wire logic       clk_sys,
  output var  logic       wr_strobe,
  output var  logic       port_select_line,
  output var  logic [7:0] wr_data
);
  initial begin
    wr_strobe        = 1'b0;
    port_select_line = 1'b0;
    wr_data          = 8'h00;
  end

  // -----------------------------------------------------------------
  // host write cycle
  // -----------------------------------------------------------------
  // strobe held 4 edges and idle 6 edges, above the 3-cycle minimum
  task automatic write(input logic sel, input logic [7:0] d);
    @(posedge clk_sys);
    wr_strobe        <= 1'b1;
    port_select_line <= sel;
    wr_data          <= d;
    repeat (4) @(posedge clk_sys);
    wr_strobe <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // released bus shows the inverse, so a stale copy is never mistaken
    wr_data          <= ~d;
    port_select_line <= ~sel;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // pcw_host_model

`default_nettype wire

/* pcw_pkg.sv */
package pcw_pkg;

  // -----------------------------------------------------------------
  // command word field positions
  // -----------------------------------------------------------------
  localparam int INIT_REQ4_BIT     = 0;
  localparam int INIT_SINGLE_BIT   = 1;
  localparam int INIT_INTERVAL_BIT = 2;
  localparam int INIT_LEVEL_BIT    = 3;
  localparam int SEL_BIT4          = 4;
  localparam int SEL_BIT3          = 3;
  localparam int MODE_PROC_BIT     = 0;
  localparam int MODE_AUTO_END_BIT = 1;
  localparam int MODE_ROLE_BIT     = 2;
  localparam int MODE_BUF_BIT      = 3;
  localparam int MODE_NEST_BIT     = 4;
  localparam int CMD_LEVEL_SEL_BIT = 6;
  localparam int CMD_END_BIT       = 5;
  localparam int CMD_ROTATE_BIT    = 7;
  localparam int READ_TARGET_BIT   = 0;
  localparam int READ_ENABLE_BIT   = 1;
  localparam int READ_POLL_BIT     = 2;
  localparam int READ_SMASK_BIT    = 5;
  localparam int READ_SMASK_EN_BIT = 6;
  localparam int PAGE_LO_MSB       = 7;
  localparam int PAGE_LO_LSB       = 5;
  localparam int VEC_MSB           = 7;
  localparam int VEC_LSB           = 3;
  localparam int LEVEL_MSB         = 2;
  localparam int LEVEL_LSB         = 0;
  localparam int PAGE_A5           = 0;
  localparam int PAGE_A7           = 2;
  localparam int PAGE_A8           = 3;
  localparam int PAGE_A15          = 10;

  // -----------------------------------------------------------------
  // reset values and constants
  // -----------------------------------------------------------------
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [2:0]  LEVEL_ZERO    = 3'h0;
  localparam logic [2:0]  LOWEST_INIT   = 3'h7;
  localparam logic [10:0] PAGE_ZERO     = 11'h000;
  localparam logic [4:0]  VEC_ZERO      = 5'h00;
  localparam logic        READ_SEL_INIT = 1'b1;

  typedef enum logic [3:0] {
    PCW_READY = 4'h1,
    PCW_BASE  = 4'h2,
    PCW_CASC  = 4'h4,
    PCW_MODE  = 4'h8
  } pcw_state_t;

endpackage : pcw_pkg

/* pcw_prog.sv */
// What this block does
// - Fourth word expected only if first word requests it; vector mode needs it.
// - Single-device flag set skips cascade word; cleared expects it.
// - Call mode interval flag: 4 locations when set, 8 when cleared.
// - Level-trigger flag 1 disables edge detection on all request inputs.
// - Call address: page bits A5-A15 programmed, A0-A4 inserted by device.
// - Vector byte: five programmed high bits, three low bits are level.
// - Master cascade word bit n set means slave on request input n.
// - Master drives byte 1, then selects slave over cascade lines.
// - Slave keeps 3-bit identity and answers only on matching cascade input.
// - Cascade word accepted only when single-device flag is 0.
// - Fourth word accepted only when requested; five bits used, upper zero.
// - Processor-mode bit: 0 call mode, 1 vector mode.
// - Auto-end bit ends each interrupt without a host command.
// - Buffered mode: master/slave bit 1 master, 0 slave; else ignored.
// - Buffer bit 1 turns dual-purpose pin into buffer enable output.
// - Special-nesting bit 1 selects special fully nested operation.
// - First operational word loads mask; special mask also masks in-service.
// - Level-select 1 makes level bits name target; set-priority makes it lowest.
// - Rotate bit applies rotation with end and level-select bits.
// - Read select 0 in-service, 1 request; read-enable applies, persists.
// - Poll bit 1 selects polling mode.
// - Special-mask enable 1 lets special-mask bit set or clear mode.
// - Address low with bit 4 set restarts init, resets edge, mask, special mask.
// - Without fourth word: non-buffered, no auto end, call mode.
`timescale 1ns/1ps
`default_nettype none

module pcw_prog
  import pcw_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       wr_strobe,
  input  wire logic       port_select_line,
  input  wire logic [7:0] wr_data,
  input  wire logic       role_pin_in,
  input  wire logic [2:0] cascade_lines_in,
  output logic            edge_reset_pulse,
  output logic            level_trigger_sel,
  output logic            address_interval_sel,
  output logic            single_device_flag,
  output logic [10:0]     page_bits,
  output logic [4:0]      vector_high_bits,
  output logic [7:0]      slave_present_bits,
  output logic [2:0]      slave_identity,
  output logic            is_master,
  output logic            slave_selected,
  output logic            processor_mode_sel,
  output logic            auto_end_sel,
  output logic            buffered_mode,
  output logic            special_nesting_sel,
  output logic            role_pin_oe,
  output logic [7:0]      mask_bits,
  output logic            special_mask_mode,
  output logic            read_target_sel,
  output logic            poll_mode,
  output logic            cmd_valid,
  output logic            end_of_interrupt_bit,
  output logic            level_select_bit,
  output logic            rotate_bit,
  output logic [2:0]      level_bits,
  output logic            init_done
);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic       wr_s1_reg, wr_s2_reg, wr_s3_reg;
  logic       psel_s1_reg, psel_s2_reg;
  logic [7:0] d_s1_reg, d_s2_reg;
  logic       role_s1_reg, role_s2_reg;
  logic [2:0] cas_s1_reg, cas_s2_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_s1_reg  <= 1'b0;
      wr_s2_reg  <= 1'b0;
      wr_s3_reg  <= 1'b0;
      psel_s1_reg <= 1'b0;
      psel_s2_reg <= 1'b0;
      d_s1_reg   <= BYTE_ZERO;
      d_s2_reg   <= BYTE_ZERO;
      role_s1_reg <= 1'b0;
      role_s2_reg <= 1'b0;
      cas_s1_reg <= LEVEL_ZERO;
      cas_s2_reg <= LEVEL_ZERO;
    end else begin
      wr_s1_reg  <= wr_strobe;
      wr_s2_reg  <= wr_s1_reg;
      wr_s3_reg  <= wr_s2_reg;
      psel_s1_reg <= port_select_line;
      psel_s2_reg <= psel_s1_reg;
      d_s1_reg   <= wr_data;
      d_s2_reg   <= d_s1_reg;
      role_s1_reg <= role_pin_in;
      role_s2_reg <= role_s1_reg;
      cas_s1_reg <= cascade_lines_in;
      cas_s2_reg <= cas_s1_reg;
    end
  end

  // -----------------------------------------------------------------
  // write decode
  // -----------------------------------------------------------------
  logic wr_go;
  logic is_init_word;
  logic is_cmd_word;
  logic is_read_word;
  logic hi_wr;

  assign wr_go        = wr_s2_reg && !wr_s3_reg;
  assign is_init_word = wr_go && !psel_s2_reg && d_s2_reg[SEL_BIT4];
  assign is_cmd_word  = wr_go && !psel_s2_reg && !d_s2_reg[SEL_BIT4] && !d_s2_reg[SEL_BIT3];
  assign is_read_word = wr_go && !psel_s2_reg && !d_s2_reg[SEL_BIT4] && d_s2_reg[SEL_BIT3];
  assign hi_wr        = wr_go && psel_s2_reg;

  // -----------------------------------------------------------------
  // initialization sequencer
  // -----------------------------------------------------------------
  pcw_state_t state_reg;
  logic       fourth_req_reg;
  logic       ms_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= PCW_READY;
      init_done <= 1'b0;
    end else if (is_init_word) begin
      state_reg <= PCW_BASE;
      init_done <= 1'b0;
    end else if (hi_wr) begin
      case (state_reg)
        PCW_BASE: begin
          if (!single_device_flag) begin
            state_reg <= PCW_CASC;
          end else if (fourth_req_reg) begin
            state_reg <= PCW_MODE;
          end else begin
            state_reg <= PCW_READY;
            init_done <= 1'b1;
          end
        end
        PCW_CASC: begin
          if (fourth_req_reg) begin
            state_reg <= PCW_MODE;
          end else begin
            state_reg <= PCW_READY;
            init_done <= 1'b1;
          end
        end
        PCW_MODE: begin
          state_reg <= PCW_READY;
          init_done <= 1'b1;
        end
        default: begin
          state_reg <= PCW_READY;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // first and second initialization words
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fourth_req_reg       <= 1'b0;
      single_device_flag   <= 1'b0;
      address_interval_sel <= 1'b0;
      level_trigger_sel    <= 1'b0;
      edge_reset_pulse     <= 1'b0;
      page_bits            <= PAGE_ZERO;
      vector_high_bits     <= VEC_ZERO;
    end else begin
      edge_reset_pulse <= is_init_word;
      if (is_init_word) begin
        fourth_req_reg       <= d_s2_reg[INIT_REQ4_BIT];
        single_device_flag   <= d_s2_reg[INIT_SINGLE_BIT];
        address_interval_sel <= d_s2_reg[INIT_INTERVAL_BIT];
        level_trigger_sel    <= d_s2_reg[INIT_LEVEL_BIT];
        page_bits[PAGE_A7:PAGE_A5] <= d_s2_reg[PAGE_LO_MSB:PAGE_LO_LSB];
      end
      if (hi_wr && state_reg == PCW_BASE) begin
        page_bits[PAGE_A15:PAGE_A8] <= d_s2_reg;
        vector_high_bits            <= d_s2_reg[VEC_MSB:VEC_LSB];
      end
    end
  end

  // -----------------------------------------------------------------
  // cascade word and slave match
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slave_present_bits <= BYTE_ZERO;
      slave_identity     <= LEVEL_ZERO;
      is_master          <= 1'b0;
      slave_selected     <= 1'b0;
    end else begin
      if (hi_wr && state_reg == PCW_CASC) begin
        slave_present_bits <= d_s2_reg;
        slave_identity     <= d_s2_reg[LEVEL_MSB:LEVEL_LSB];
      end
      is_master      <= buffered_mode ? ms_reg : role_s2_reg;
      slave_selected <= !is_master && !single_device_flag &&
                        (cas_s2_reg == slave_identity);
    end
  end

  // -----------------------------------------------------------------
  // fourth initialization word
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      processor_mode_sel  <= 1'b0;
      auto_end_sel        <= 1'b0;
      ms_reg              <= 1'b0;
      buffered_mode       <= 1'b0;
      special_nesting_sel <= 1'b0;
      role_pin_oe         <= 1'b0;
    end else begin
      if (is_init_word) begin
        processor_mode_sel  <= 1'b0;
        auto_end_sel        <= 1'b0;
        ms_reg              <= 1'b0;
        buffered_mode       <= 1'b0;
        special_nesting_sel <= 1'b0;
      end else if (hi_wr && state_reg == PCW_MODE) begin
        processor_mode_sel  <= d_s2_reg[MODE_PROC_BIT];
        auto_end_sel        <= d_s2_reg[MODE_AUTO_END_BIT];
        ms_reg              <= d_s2_reg[MODE_ROLE_BIT];
        buffered_mode       <= d_s2_reg[MODE_BUF_BIT];
        special_nesting_sel <= d_s2_reg[MODE_NEST_BIT];
      end
      role_pin_oe <= buffered_mode;
    end
  end

  // -----------------------------------------------------------------
  // operational words
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mask_bits         <= BYTE_ZERO;
      special_mask_mode <= 1'b0;
      read_target_sel   <= READ_SEL_INIT;
      poll_mode         <= 1'b0;
    end else begin
      poll_mode <= 1'b0;
      if (is_init_word) begin
        mask_bits         <= BYTE_ZERO;
        special_mask_mode <= 1'b0;
        read_target_sel   <= READ_SEL_INIT;
      end else begin
        if (hi_wr && state_reg == PCW_READY) begin
          mask_bits <= d_s2_reg;
        end
        if (is_read_word) begin
          if (d_s2_reg[READ_ENABLE_BIT]) begin
            read_target_sel <= d_s2_reg[READ_TARGET_BIT];
          end
          if (d_s2_reg[READ_SMASK_EN_BIT]) begin
            special_mask_mode <= d_s2_reg[READ_SMASK_BIT];
          end
          poll_mode <= d_s2_reg[READ_POLL_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_valid            <= 1'b0;
      end_of_interrupt_bit <= 1'b0;
      level_select_bit     <= 1'b0;
      rotate_bit           <= 1'b0;
      level_bits           <= LOWEST_INIT;
    end else begin
      cmd_valid <= is_cmd_word;
      if (is_init_word) begin
        level_bits <= LOWEST_INIT;
      end else if (is_cmd_word) begin
        end_of_interrupt_bit <= d_s2_reg[CMD_END_BIT];
        level_select_bit     <= d_s2_reg[CMD_LEVEL_SEL_BIT];
        rotate_bit           <= d_s2_reg[CMD_ROTATE_BIT];
        level_bits           <= d_s2_reg[LEVEL_MSB:LEVEL_LSB];
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  chk_init_clears_mask: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_init_word |=> (mask_bits == BYTE_ZERO) && !special_mask_mode && edge_reset_pulse)
    else $error("init word did not clear mask state");
  chk_single_skips_cas: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hi_wr && state_reg == PCW_BASE && single_device_flag) |=> state_reg != PCW_CASC)
    else $error("cascade word expected in single mode");
  chk_mode_defaults: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_init_word |=> !processor_mode_sel && !auto_end_sel && !buffered_mode)
    else $error("fourth word defaults not restored");
  chk_mode_needs_req: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == PCW_MODE) |-> fourth_req_reg)
    else $error("fourth word state without request");
  chk_mask_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hi_wr && state_reg == PCW_READY) |=> mask_bits == $past(d_s2_reg))
    else $error("mask word not loaded");
  chk_smask_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_read_word && !d_s2_reg[READ_SMASK_EN_BIT]) |=> $stable(special_mask_mode))
    else $error("special mask changed without enable");
  chk_read_persist: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_read_word && !d_s2_reg[READ_ENABLE_BIT] && !is_init_word) |=> $stable(read_target_sel))
    else $error("read select changed without read enable");
  chk_read_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    (is_read_word && d_s2_reg[READ_ENABLE_BIT]) |=> read_target_sel == $past(d_s2_reg[READ_TARGET_BIT]))
    else $error("read select not applied");
  chk_cascade_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hi_wr && state_reg == PCW_CASC) |=> (slave_present_bits == $past(d_s2_reg)) &&
      (slave_identity == $past(d_s2_reg[LEVEL_MSB:LEVEL_LSB])))
    else $error("cascade word not loaded");
  chk_mode_load: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hi_wr && state_reg == PCW_MODE) |=> (processor_mode_sel == $past(d_s2_reg[MODE_PROC_BIT])) &&
      (auto_end_sel == $past(d_s2_reg[MODE_AUTO_END_BIT])) && (special_nesting_sel == $past(d_s2_reg[MODE_NEST_BIT])))
    else $error("fourth word fields not loaded");
  chk_role_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    buffered_mode |=> (is_master == $past(ms_reg)))
    else $error("buffered role not taken from fourth word");
  chk_slave_match: assert property (@(posedge clk_sys) disable iff (!resetn)
    slave_selected |-> ($past(cas_s2_reg) == $past(slave_identity)) && !$past(is_master))
    else $error("slave selected without identity match");
  chk_poll_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
    poll_mode |-> $past(is_read_word && d_s2_reg[READ_POLL_BIT]))
    else $error("poll pulse without poll command");
  chk_cmd_fields: assert property (@(posedge clk_sys) disable iff (!resetn)
    is_cmd_word |=> cmd_valid && (level_bits == $past(d_s2_reg[LEVEL_MSB:LEVEL_LSB])))
    else $error("command word fields not loaded");
  chk_buf_pin: assert property (@(posedge clk_sys) disable iff (!resetn)
    buffered_mode |=> role_pin_oe)
    else $error("buffer enable pin not driven");

endmodule // pcw_prog

`default_nettype wire

/* pcw_prog_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module pcw_prog_tb;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  logic        clk_sys, resetn, role_pin_in, wr_strobe, port_select_line;
  logic [2:0]  cascade_lines_in, slave_identity, level_bits;
  logic [7:0]  wr_data, slave_present_bits, mask_bits;
  logic [10:0] page_bits;
  logic [4:0]  vector_high_bits;
  logic        edge_reset_pulse, level_trigger_sel, address_interval_sel, single_device_flag;
  logic        is_master, slave_selected, processor_mode_sel, auto_end_sel, buffered_mode;
  logic        special_nesting_sel, role_pin_oe, special_mask_mode, read_target_sel, poll_mode;
  logic        cmd_valid, end_of_interrupt_bit, level_select_bit, rotate_bit, init_done;
  int          n_errors = 0, comparisons = 0, n_edge = 0, n_poll = 0, n_cmd = 0;
  logic [7:0]  cmd_tab [3] = '{8'hE3, 8'h20, 8'hC5};

  pcw_host_model i_host (.clk_sys(clk_sys), .wr_strobe(wr_strobe),
    .port_select_line(port_select_line), .wr_data(wr_data));

  pcw_prog i_dut (.clk_sys(clk_sys), .resetn(resetn), .wr_strobe(wr_strobe),
    .port_select_line(port_select_line), .wr_data(wr_data), .role_pin_in(role_pin_in),
    .cascade_lines_in(cascade_lines_in), .edge_reset_pulse(edge_reset_pulse),
    .level_trigger_sel(level_trigger_sel), .address_interval_sel(address_interval_sel),
    .single_device_flag(single_device_flag), .page_bits(page_bits),
    .vector_high_bits(vector_high_bits), .slave_present_bits(slave_present_bits),
    .slave_identity(slave_identity), .is_master(is_master), .slave_selected(slave_selected),
    .processor_mode_sel(processor_mode_sel), .auto_end_sel(auto_end_sel),
    .buffered_mode(buffered_mode), .special_nesting_sel(special_nesting_sel),
    .role_pin_oe(role_pin_oe), .mask_bits(mask_bits), .special_mask_mode(special_mask_mode),
    .read_target_sel(read_target_sel), .poll_mode(poll_mode), .cmd_valid(cmd_valid),
    .end_of_interrupt_bit(end_of_interrupt_bit), .level_select_bit(level_select_bit),
    .rotate_bit(rotate_bit), .level_bits(level_bits), .init_done(init_done));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // one-cycle pulses are counted as they pass
  always @(posedge clk_sys) begin
    if (edge_reset_pulse === 1'b1) n_edge++;
    if (poll_mode === 1'b1) n_poll++;
    if (cmd_valid === 1'b1) n_cmd++;
  end

  // -----------------------------------------------------------------
  // compare and report
  // -----------------------------------------------------------------
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %0t pulse count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("[ERR] %0t run timed out", $time);
    summarize();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    resetn           = 1'b0;
    role_pin_in      = 1'b0;
    cascade_lines_in = 3'h0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    chk(11'({level_bits, mask_bits}), 11'h700);
    chk(11'(read_target_sel), 11'h001);
    chk(11'({processor_mode_sel, auto_end_sel, buffered_mode, init_done}), 11'h000);
    i_host.write(1'b1, 8'hA5);
    chk(11'(mask_bits), 11'h0A5);
    // single device, fourth word requested, vector mode
    i_host.write(1'b0, 8'hBF);
    chk_cnt(n_edge, 1);
    chk(11'(mask_bits), 11'h000);
    chk(11'({level_trigger_sel, address_interval_sel, single_device_flag}), 11'h007);
    i_host.write(1'b1, 8'h5A);
    chk(page_bits, 11'h2D5);
    chk(11'(vector_high_bits), 11'h00B);
    chk(11'(init_done), 11'h000);
    i_host.write(1'b1, 8'h1F);
    chk(11'({processor_mode_sel, auto_end_sel, buffered_mode, special_nesting_sel}), 11'h00F);
    chk(11'({is_master, role_pin_oe, init_done}), 11'h007);
    chk(11'(slave_present_bits), 11'h000);
    i_host.write(1'b1, 8'h3C);
    chk(11'(mask_bits), 11'h03C);
    // third operational word: special mask, read select, poll
    i_host.write(1'b0, 8'h6A);
    chk(11'({special_mask_mode, read_target_sel}), 11'h002);
    i_host.write(1'b0, 8'h28);
    chk(11'({special_mask_mode, read_target_sel}), 11'h002);
    i_host.write(1'b0, 8'h0C);
    chk_cnt(n_poll, 1);
    chk(11'(mask_bits), 11'h03C);
    // second operational word: specific rotate, non-specific, set priority
    for (int i = 0; i < 3; i++) begin
      i_host.write(1'b0, cmd_tab[i]);
      chk_cnt(n_cmd, i + 1);
      chk(11'({rotate_bit, level_select_bit, end_of_interrupt_bit, level_bits}),
          11'({cmd_tab[i][7:5], cmd_tab[i][2:0]}));
    end
    chk_cnt(n_poll, 1);
    // cascaded re-init without fourth word
    i_host.write(1'b0, 8'h10);
    chk_cnt(n_edge, 2);
    chk(11'({special_mask_mode, read_target_sel, mask_bits}), 11'h100);
    i_host.write(1'b1, 8'hF8);
    i_host.write(1'b1, 8'hFD);
    chk(11'(slave_present_bits), 11'h0FD);
    chk(11'(slave_identity), 11'h005);
    chk(11'({processor_mode_sel, auto_end_sel, buffered_mode, role_pin_oe, init_done}), 11'h001);
    chk(11'({level_trigger_sel, address_interval_sel, single_device_flag}), 11'h000);
    chk(page_bits, 11'h7C0);
    cascade_lines_in <= 3'h5;
    repeat (6) @(posedge clk_sys);
    chk(11'({is_master, slave_selected}), 11'h001);
    cascade_lines_in <= 3'h3;
    repeat (6) @(posedge clk_sys);
    chk(11'({is_master, slave_selected}), 11'h000);
    role_pin_in      <= 1'b1;
    cascade_lines_in <= 3'h5;
    repeat (6) @(posedge clk_sys);
    chk(11'({is_master, slave_selected}), 11'h002);
    i_host.write(1'b1, 8'h81);
    chk(11'(mask_bits), 11'h081);
    summarize();
  end
endmodule // pcw_prog_tb

`default_nettype wire
